// ---- cpu_program_model_stack.v ----
// Purpose: Programming-model registers of an 8-bit core with its hardware stack sequencing.
// Assumes: Memory answers a read with mem_rdata_in in the same cycle that mem_re_out is high; op inputs share clk_in.
// Notes: Commands are taken only while busy_out is low; straps are synchronised before use.
`include "cpu_program_model_defines.vh"
`default_nettype none

module cpu_program_model_stack (
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire boot_mode_in,
  input wire [1:0] reset_cause_in,
  input wire op_valid_in,
  input wire [4:0] op_code_in,
  input wire [15:0] op_data_in,
  input wire [2:0] op_len_in,
  input wire [7:0] mem_rdata_in,
  output wire [15:0] mem_addr_out,
  output wire [7:0] mem_wdata_out,
  output wire mem_we_out,
  output wire mem_re_out,
  output wire busy_out,
  output wire done_out,
  output wire [7:0] acc1_out,
  output wire [7:0] acc2_out,
  output wire [15:0] index1_out,
  output wire [15:0] index2_out,
  output wire [15:0] sp_out,
  output wire [15:0] pc_out,
  output wire [7:0] flags_out,
  output wire [15:0] eff_addr_out
);

  // ----------------------------------------------------------------------
  // Sequencer states.
  // ----------------------------------------------------------------------
  localparam ST_VSEL = 3'h0;
  localparam ST_IDLE = 3'h1;
  localparam ST_EXTRA = 3'h2;
  localparam ST_EXEC = 3'h3;
  localparam ST_PUSH = 3'h4;
  localparam ST_RD = 3'h5;
  localparam ST_RD_W = 3'h6;
  localparam ST_FIN = 3'h7;

  // ----------------------------------------------------------------------
  // Helper functions.
  // ----------------------------------------------------------------------
  function uses_index2;
    input [4:0] op;
    begin
      uses_index2 = (op == `OP_LOAD_INDEX2) || (op == `OP_ADD_ACC2_TO_INDEX2) || (op == `OP_INDEXED_ADDR2) ||
                    (op == `OP_PUSH_INDEX2) || (op == `OP_PULL_INDEX2);
    end
  endfunction

  function [15:0] reset_vector;
    input boot;
    input [1:0] cause;
    begin
      if (cause == 2'h1) begin
        reset_vector = boot ? `VEC_BOOT_CLKMON : `VEC_NORMAL_CLKMON;
      end else if (cause == 2'h2) begin
        reset_vector = boot ? `VEC_BOOT_WATCHDOG : `VEC_NORMAL_WATCHDOG;
      end else begin
        reset_vector = boot ? `VEC_BOOT_POR : `VEC_NORMAL_POR;
      end
    end
  endfunction

  // Software may clear the X mask but never set it.
  function [7:0] merge_flags;
    input [7:0] old_flags;
    input [7:0] new_flags;
    begin
      merge_flags = new_flags;
      merge_flags[`FLAG_X] = new_flags[`FLAG_X] & old_flags[`FLAG_X];
    end
  endfunction

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  reg [2:0] state_q;
  reg [4:0] op_q;
  reg [15:0] data_q;
  reg [2:0] len_q;
  reg [7:0] acc1_q;
  reg [7:0] acc2_q;
  reg [15:0] index1_q;
  reg [15:0] index2_q;
  reg [15:0] sp_q;
  reg [15:0] pc_q;
  reg [7:0] flags_q;
  reg [15:0] eff_addr_q;
  reg [71:0] buf_q;
  reg [3:0] cnt_q;
  reg stack_rd_q;
  reg vec_q;
  reg [15:0] rd_addr_q;
  reg [15:0] mem_addr_q;
  reg [7:0] mem_wdata_q;
  reg mem_we_q;
  reg mem_re_q;
  reg busy_q;
  reg done_q;
  reg mode_s1_q;
  reg mode_s2_q;
  reg [1:0] cause_s1_q;
  reg [1:0] cause_s2_q;

  wire [7:0] alu_result;
  wire [7:0] alu_flags;
  reg [1:0] alu_sel;
  wire [15:0] next_pc;

  // second-index commands carry one extra opcode byte.
  assign next_pc = pc_q + {13'h0000, len_q} + {15'h0000, uses_index2(op_q)};

  always @* begin
    if (op_q == `OP_DECIMAL_ADJUST) begin
      alu_sel = `ALU_DAA;
    end else if (op_q == `OP_SUB_ACC2_FROM_ACC1) begin
      alu_sel = `ALU_SUB;
    end else if (op_q == `OP_COMPARE_ACC1_ACC2) begin
      alu_sel = `ALU_CMP;
    end else begin
      alu_sel = `ALU_ADD;
    end
  end

  // Operands are wired one way only: first accumulator is destination, second is source.
  acc_alu u_alu (
    .acc1_in(acc1_q),
    .acc2_in(acc2_q),
    .flags_in(flags_q),
    .sel_in(alu_sel),
    .result_out(alu_result),
    .flags_out(alu_flags)
  );

  // ----------------------------------------------------------------------
  // Strap synchronisers.
  // ----------------------------------------------------------------------
  always @(posedge clk_in) begin
    if (ce_in) begin
      mode_s1_q <= boot_mode_in;
      mode_s2_q <= mode_s1_q;
      cause_s1_q <= reset_cause_in;
      cause_s2_q <= cause_s1_q;
    end
  end

  // ----------------------------------------------------------------------
  // Register file and stack sequencer.
  // ----------------------------------------------------------------------
  always @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= ST_VSEL;
      op_q <= `OP_NOP;
      data_q <= `WORD_RESET;
      len_q <= 3'h0;
      acc1_q <= `BYTE_RESET;
      acc2_q <= `BYTE_RESET;
      index1_q <= `WORD_RESET;
      index2_q <= `WORD_RESET;
      sp_q <= `WORD_RESET;
      pc_q <= `WORD_RESET;
      flags_q <= `FLAGS_RESET;
      eff_addr_q <= `WORD_RESET;
      buf_q <= 72'h000000000000000000;
      cnt_q <= 4'h0;
      stack_rd_q <= 1'b0;
      vec_q <= 1'b0;
      rd_addr_q <= `WORD_RESET;
      mem_addr_q <= `WORD_RESET;
      mem_wdata_q <= `BYTE_RESET;
      mem_we_q <= 1'b0;
      mem_re_q <= 1'b0;
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end else if (ce_in) begin
      mem_we_q <= 1'b0;
      mem_re_q <= 1'b0;
      done_q <= 1'b0;
      case (state_q)
        ST_VSEL: begin
          rd_addr_q <= reset_vector(mode_s2_q, cause_s2_q);
          op_q <= `OP_INTERRUPT_ENTRY;
          vec_q <= 1'b1;
          stack_rd_q <= 1'b0;
          cnt_q <= 4'h2;
          state_q <= ST_RD;
        end
        ST_IDLE: begin
          if (op_valid_in) begin
            op_q <= op_code_in;
            data_q <= op_data_in;
            len_q <= op_len_in;
            busy_q <= 1'b1;
            state_q <= uses_index2(op_code_in) ? ST_EXTRA : ST_EXEC;
          end
        end
        ST_EXTRA: begin
          state_q <= ST_EXEC;
        end
        ST_EXEC: begin
          state_q <= ST_FIN;
          stack_rd_q <= 1'b1;
          vec_q <= 1'b0;
          case (op_q)
            `OP_LOAD_ACC1: acc1_q <= data_q[7:0];
            `OP_LOAD_ACC2: acc2_q <= data_q[7:0];
            `OP_LOAD_ACC16: begin
              acc1_q <= data_q[15:8];
              acc2_q <= data_q[7:0];
            end
            `OP_LOAD_INDEX1: index1_q <= data_q;
            `OP_LOAD_INDEX2: index2_q <= data_q;
            `OP_LOAD_SP: sp_q <= data_q;
            `OP_ADD_ACC2_TO_INDEX1: index1_q <= index1_q + {8'h00, acc2_q};
            `OP_ADD_ACC2_TO_INDEX2: index2_q <= index2_q + {8'h00, acc2_q};
            `OP_FLAGS_TO_ACC1: acc1_q <= flags_q;
            `OP_ACC1_TO_FLAGS: flags_q <= merge_flags(flags_q, acc1_q);
            `OP_DECIMAL_ADJUST, `OP_ADD_ACC2_INTO_ACC1, `OP_SUB_ACC2_FROM_ACC1: begin
              acc1_q <= alu_result;
              flags_q <= alu_flags;
            end
            `OP_COMPARE_ACC1_ACC2: flags_q <= alu_flags;
            `OP_INDEXED_ADDR1: eff_addr_q <= index1_q + {8'h00, data_q[7:0]};
            `OP_INDEXED_ADDR2: eff_addr_q <= index2_q + {8'h00, data_q[7:0]};
            `OP_JUMP_TO_SUBROUTINE, `OP_BRANCH_TO_SUBROUTINE: begin
              buf_q <= {56'h00000000000000, next_pc};
              cnt_q <= 4'h2;
              state_q <= ST_PUSH;
            end
            `OP_INTERRUPT_ENTRY: begin
              buf_q <= {flags_q, acc2_q, acc1_q, index1_q, index2_q, pc_q};
              cnt_q <= `INT_FRAME_BYTES;
              state_q <= ST_PUSH;
            end
            `OP_PUSH_ACC1, `OP_PUSH_ACC2: begin
              buf_q <= {64'h0000000000000000, (op_q == `OP_PUSH_ACC1) ? acc1_q : acc2_q};
              cnt_q <= 4'h1;
              state_q <= ST_PUSH;
            end
            `OP_PUSH_INDEX1, `OP_PUSH_INDEX2: begin
              buf_q <= {56'h00000000000000, (op_q == `OP_PUSH_INDEX1) ? index1_q : index2_q};
              cnt_q <= 4'h2;
              state_q <= ST_PUSH;
            end
            `OP_RETURN_FROM_SUBROUTINE, `OP_PULL_INDEX1, `OP_PULL_INDEX2: begin
              cnt_q <= 4'h2;
              state_q <= ST_RD;
            end
            `OP_RETURN_FROM_INTERRUPT: begin
              cnt_q <= `INT_FRAME_BYTES;
              state_q <= ST_RD;
            end
            `OP_PULL_ACC1, `OP_PULL_ACC2: begin
              cnt_q <= 4'h1;
              state_q <= ST_RD;
            end
            default: begin
            end
          endcase
        end
        ST_PUSH: begin
          mem_we_q <= 1'b1;
          mem_addr_q <= sp_q;
          mem_wdata_q <= buf_q[7:0];
          buf_q <= {8'h00, buf_q[71:8]};
          sp_q <= sp_q - 16'h0001;
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1) begin
            state_q <= ST_FIN;
          end
        end
        ST_RD: begin
          mem_re_q <= 1'b1;
          if (stack_rd_q) begin
            mem_addr_q <= sp_q + 16'h0001;
            sp_q <= sp_q + 16'h0001;
          end else begin
            mem_addr_q <= rd_addr_q;
            rd_addr_q <= rd_addr_q + 16'h0001;
          end
          cnt_q <= cnt_q - 4'h1;
          state_q <= ST_RD_W;
        end
        ST_RD_W: begin
          buf_q <= {buf_q[63:0], mem_rdata_in};
          state_q <= (cnt_q == 4'h0) ? ST_FIN : ST_RD;
        end
        default: begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          state_q <= ST_IDLE;
          pc_q <= next_pc;
          case (op_q)
            `OP_JUMP_TO_SUBROUTINE: pc_q <= data_q;
            `OP_BRANCH_TO_SUBROUTINE: pc_q <= next_pc + {{8{data_q[7]}}, data_q[7:0]};
            `OP_RETURN_FROM_SUBROUTINE: pc_q <= buf_q[15:0];
            `OP_INTERRUPT_ENTRY: begin
              if (!vec_q) begin
                flags_q[`FLAG_I] <= 1'b1;
                rd_addr_q <= data_q;
                vec_q <= 1'b1;
                stack_rd_q <= 1'b0;
                cnt_q <= 4'h2;
                busy_q <= 1'b1;
                done_q <= 1'b0;
                state_q <= ST_RD;
              end else begin
                pc_q <= buf_q[15:0];
              end
            end
            `OP_RETURN_FROM_INTERRUPT: begin
              flags_q <= merge_flags(flags_q, buf_q[71:64]);
              acc2_q <= buf_q[63:56];
              acc1_q <= buf_q[55:48];
              index1_q <= buf_q[47:32];
              index2_q <= buf_q[31:16];
              pc_q <= buf_q[15:0];
            end
            `OP_PULL_ACC1: acc1_q <= buf_q[7:0];
            `OP_PULL_ACC2: acc2_q <= buf_q[7:0];
            `OP_PULL_INDEX1: index1_q <= buf_q[15:0];
            `OP_PULL_INDEX2: index2_q <= buf_q[15:0];
            default: begin
            end
          endcase
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Outputs: model registers are exposed only as ports, never as memory.
  // ----------------------------------------------------------------------
  assign mem_addr_out = mem_addr_q;
  assign mem_wdata_out = mem_wdata_q;
  assign mem_we_out = mem_we_q;
  assign mem_re_out = mem_re_q;
  assign busy_out = busy_q;
  assign done_out = done_q;
  assign acc1_out = acc1_q;
  assign acc2_out = acc2_q;
  assign index1_out = index1_q;
  assign index2_out = index2_q;
  assign sp_out = sp_q;
  assign pc_out = pc_q;
  assign flags_out = flags_q;
  assign eff_addr_out = eff_addr_q;

endmodule // cpu_program_model_stack
`default_nettype wire

// ---- cpu_program_model_defines.vh ----
// Purpose: Constants shared by the programming-model register file and its accumulator unit.
// Assumes: Included by its bare name from each design file.
// Notes: Command codes, flag positions, reset values and reset vectors.
`ifndef CPU_PROGRAM_MODEL_DEFINES_VH
`define CPU_PROGRAM_MODEL_DEFINES_VH

// ----------------------------------------------------------------------
// Command codes on op_code_in.
// ----------------------------------------------------------------------
`define OP_NOP 5'h00
`define OP_LOAD_ACC1 5'h01
`define OP_LOAD_ACC2 5'h02
`define OP_LOAD_ACC16 5'h03
`define OP_LOAD_INDEX1 5'h04
`define OP_LOAD_INDEX2 5'h05
`define OP_LOAD_SP 5'h06
`define OP_ADD_ACC2_TO_INDEX1 5'h07
`define OP_ADD_ACC2_TO_INDEX2 5'h08
`define OP_FLAGS_TO_ACC1 5'h09
`define OP_ACC1_TO_FLAGS 5'h0a
`define OP_DECIMAL_ADJUST 5'h0b
`define OP_ADD_ACC2_INTO_ACC1 5'h0c
`define OP_SUB_ACC2_FROM_ACC1 5'h0d
`define OP_COMPARE_ACC1_ACC2 5'h0e
`define OP_INDEXED_ADDR1 5'h0f
`define OP_INDEXED_ADDR2 5'h10
`define OP_JUMP_TO_SUBROUTINE 5'h11
`define OP_BRANCH_TO_SUBROUTINE 5'h12
`define OP_RETURN_FROM_SUBROUTINE 5'h13
`define OP_INTERRUPT_ENTRY 5'h14
`define OP_RETURN_FROM_INTERRUPT 5'h15
`define OP_PUSH_ACC1 5'h16
`define OP_PUSH_ACC2 5'h17
`define OP_PUSH_INDEX1 5'h18
`define OP_PUSH_INDEX2 5'h19
`define OP_PULL_ACC1 5'h1a
`define OP_PULL_ACC2 5'h1b
`define OP_PULL_INDEX1 5'h1c
`define OP_PULL_INDEX2 5'h1d

// ----------------------------------------------------------------------
// Accumulator unit selections.
// ----------------------------------------------------------------------
`define ALU_ADD 2'h0
`define ALU_SUB 2'h1
`define ALU_CMP 2'h2
`define ALU_DAA 2'h3

// ----------------------------------------------------------------------
// Condition flag bit positions.
// ----------------------------------------------------------------------
`define FLAG_C 0
`define FLAG_V 1
`define FLAG_Z 2
`define FLAG_N 3
`define FLAG_I 4
`define FLAG_H 5
`define FLAG_X 6
`define FLAG_S 7

// ----------------------------------------------------------------------
// Reset values and frame sizes.
// ----------------------------------------------------------------------
`define FLAGS_RESET 8'hd0
`define WORD_RESET 16'h0000
`define BYTE_RESET 8'h00
`define INT_FRAME_BYTES 4'h9

// ----------------------------------------------------------------------
// Reset vectors by mode and cause.
// ----------------------------------------------------------------------
`define VEC_NORMAL_POR 16'hfffe
`define VEC_NORMAL_CLKMON 16'hfffc
`define VEC_NORMAL_WATCHDOG 16'hfffa
`define VEC_BOOT_POR 16'hbffe
`define VEC_BOOT_CLKMON 16'hbffc
`define VEC_BOOT_WATCHDOG 16'hbffa

`endif

// ---- acc_alu.v ----
// Purpose: Combinational accumulator arithmetic: add, subtract, compare and decimal adjust.
// Assumes: First operand is the first accumulator, second operand the second accumulator.
// Notes: Only condition flags touched by these operations change.
`include "cpu_program_model_defines.vh"
`default_nettype none

module acc_alu (
  input wire [7:0] acc1_in,
  input wire [7:0] acc2_in,
  input wire [7:0] flags_in,
  input wire [1:0] sel_in,
  output reg [7:0] result_out,
  output reg [7:0] flags_out
);

  reg [8:0] wide;
  reg [4:0] half;
  reg [7:0] adj;
  reg carry_new;

  always @* begin
    wide = 9'h000;
    half = 5'h00;
    adj = 8'h00;
    carry_new = 1'b0;
    result_out = acc1_in;
    flags_out = flags_in;
    case (sel_in)
      `ALU_ADD: begin
        wide = {1'b0, acc1_in} + {1'b0, acc2_in};
        half = {1'b0, acc1_in[3:0]} + {1'b0, acc2_in[3:0]};
        result_out = wide[7:0];
        flags_out[`FLAG_H] = half[4];
        flags_out[`FLAG_C] = wide[8];
        flags_out[`FLAG_V] = (acc1_in[7] == acc2_in[7]) && (wide[7] != acc1_in[7]);
      end
      `ALU_SUB, `ALU_CMP: begin
        wide = {1'b0, acc1_in} - {1'b0, acc2_in};
        if (sel_in == `ALU_SUB) begin
          result_out = wide[7:0];
        end
        flags_out[`FLAG_C] = wide[8];
        flags_out[`FLAG_V] = (acc1_in[7] != acc2_in[7]) && (wide[7] != acc1_in[7]);
      end
      default: begin
        carry_new = flags_in[`FLAG_C] || (acc1_in > 8'h99);
        if (flags_in[`FLAG_H] || (acc1_in[3:0] > 4'h9)) begin
          adj[3:0] = 4'h6;
        end
        if (carry_new) begin
          adj[7:4] = 4'h6;
        end
        wide = {1'b0, acc1_in} + {1'b0, adj};
        result_out = wide[7:0];
        flags_out[`FLAG_C] = carry_new;
      end
    endcase
    flags_out[`FLAG_N] = wide[7];
    flags_out[`FLAG_Z] = (wide[7:0] == 8'h00);
  end

endmodule // acc_alu
`default_nettype wire

// ---- shared_mem_model.sv ----
// Purpose: Byte memory that stands on the far side of the core's memory bus.
// Assumes: One clock; read data stands in the same cycle as the read strobe.
// Notes: Between reads the data lines toggle, so stale data matches the last read again every second cycle after that read.
`default_nettype none
module shared_mem_model (
  input wire logic clk_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic we_in,
  input wire logic re_in,
  output wire logic [7:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem_q [0:65535];
  logic [7:0] rd_q = 8'h5a;
  assign rdata_out = re_in ? mem_q[addr_in] : rd_q;
  always @(posedge clk_in) begin
    if (we_in) begin
      mem_q[addr_in] <= wdata_in;
    end
    if (re_in) begin
      rd_q <= mem_q[addr_in];
    end else begin
      rd_q <= ~rd_q;
    end
  end
endmodule // shared_mem_model
`default_nettype wire

// ---- cpu_program_model_stack_checker.sv ----
// Purpose: Port-level timing checks of the register file and stack sequencer.
// Assumes: Single clock domain, synchronous active-high reset.
// Notes: Attached to every instance of the top module by bind.
`default_nettype none
module cpu_program_model_stack_checker (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic op_valid_in,
  input wire logic [15:0] mem_addr_out,
  input wire logic mem_we_out,
  input wire logic mem_re_out,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic [7:0] acc1_out,
  input wire logic [7:0] acc2_out,
  input wire logic [15:0] index1_out,
  input wire logic [15:0] index2_out,
  input wire logic [15:0] sp_out,
  input wire logic [15:0] pc_out,
  input wire logic [7:0] flags_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  strobe_excl_a: assert property (!(mem_we_out && mem_re_out))
    else $error("read and write strobes together");
  push_addr_a: assert property (mem_we_out |-> sp_out == mem_addr_out - 16'h1)
    else $error("stack pointer not one below written byte");
  write_run_a: assert property ((mem_we_out && $past(mem_we_out)) |-> mem_addr_out == $past(mem_addr_out) - 16'h1)
    else $error("consecutive pushes not descending");
  access_busy_a: assert property ((mem_we_out || mem_re_out) |-> busy_out)
    else $error("memory access while idle");
  done_pulse_a: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  done_idle_a: assert property (done_out |-> !busy_out)
    else $error("done while busy");
  take_busy_a: assert property ((!busy_out && op_valid_in && ce_in) |=> busy_out)
    else $error("command not taken");
  idle_stable_a: assert property ((!busy_out && !op_valid_in) |=>
    $stable({acc1_out, acc2_out, index1_out, index2_out, sp_out, pc_out, flags_out}))
    else $error("registers changed while idle");
  reset_vec_a: assert property ($fell(rst_in) |-> ##[1:3] (mem_re_out && mem_addr_out[15]
    && mem_addr_out[13:4] == 10'h3ff && !mem_addr_out[0])) else $error("no vector read after reset");
  cover property (done_out);
  cover property (mem_we_out ##1 mem_we_out);
  cover property ($fell(rst_in));
endmodule // cpu_program_model_stack_checker
bind cpu_program_model_stack cpu_program_model_stack_checker chk_u (.clk_in, .rst_in, .ce_in, .op_valid_in,
  .mem_addr_out, .mem_we_out, .mem_re_out, .busy_out, .done_out, .acc1_out, .acc2_out, .index1_out,
  .index2_out, .sp_out, .pc_out, .flags_out);
`default_nettype wire

// ---- cpu_program_model_stack_bench.sv ----
// Purpose: Self-checking bench for the register file and stack sequencer.
// Assumes: Memory model answers reads in the same cycle as the read strobe.
// Notes: Expected values come from mirror registers kept by the driver.
`include "cpu_program_model_defines.vh"
`default_nettype none
module cpu_program_model_stack_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {int seq; int sel; logic [15:0] val;} note_t;
  note_t notes[$];
  logic [23:0] wq[$];
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic boot_mode_in = 1'b0;
  logic [1:0] reset_cause_in = 2'h0;
  logic op_valid_in = 1'b0;
  logic [4:0] op_code_in = 5'h00;
  logic [15:0] op_data_in = 16'h0000;
  logic [2:0] op_len_in = 3'h1;
  wire logic [7:0] mem_rdata_in, mem_wdata_out, acc1_out, acc2_out, flags_out;
  wire logic [15:0] mem_addr_out, index1_out, index2_out, sp_out, pc_out, eff_addr_out;
  wire logic mem_we_out, mem_re_out, busy_out, done_out;
  wire logic [127:0] obs = {eff_addr_out, 8'h0, flags_out, pc_out, sp_out, index2_out, index1_out,
    8'h0, acc2_out, 8'h0, acc1_out};
  logic [7:0] a, b, f;
  logic [15:0] x, y, stk, pc, ret, v;
  logic [23:0] w;
  logic [7:0] fr[9];
  integer seed = 32'h844e6765;
  int error_cnt = 0, checked = 0, op_cnt = 0, dn = 0, cyc = 0, waits = 0, lat = 0, p = 0, q = 0;
  cpu_program_model_stack dut_u (.clk_in, .rst_in, .ce_in, .boot_mode_in, .reset_cause_in, .op_valid_in,
    .op_code_in, .op_data_in, .op_len_in, .mem_rdata_in, .mem_addr_out, .mem_wdata_out, .mem_we_out, .mem_re_out,
    .busy_out, .done_out, .acc1_out, .acc2_out, .index1_out, .index2_out, .sp_out, .pc_out, .flags_out,
    .eff_addr_out);
  shared_mem_model mem_u (.clk_in, .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .we_in(mem_we_out),
    .re_in(mem_re_out), .rdata_out(mem_rdata_in));
  always #50 clk_in = ~clk_in;
  // ----------------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------------
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    cmp(16'(notes.size() + wq.size()), 16'h0);
    $display("errors=%0d checks=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic note(input int sel, input logic [15:0] val);
    notes.push_back('{op_cnt, sel, val});
  endtask
  task automatic wr(input logic [15:0] ad, input logic [7:0] d);
    wq.push_back({ad, d});
  endtask
  task automatic idle;
    waits = 0;
    @(posedge clk_in);
    #1;
    while (busy_out !== 1'b0) begin
      waits++;
      @(posedge clk_in);
      #1;
    end
  endtask
  task automatic run(input logic [4:0] c, input logic [15:0] d, input logic [2:0] len);
    idle();
    op_valid_in = 1'b1;
    op_code_in = c;
    op_data_in = d;
    op_len_in = len;
    @(posedge clk_in);
    #1;
    op_valid_in = 1'b0;
    op_cnt++;
    if (c < `OP_JUMP_TO_SUBROUTINE || c > `OP_RETURN_FROM_INTERRUPT) begin
      pc = pc + 16'(len) + ((c == `OP_LOAD_INDEX2 || c == `OP_ADD_ACC2_TO_INDEX2 || c == `OP_INDEXED_ADDR2
        || c == `OP_PUSH_INDEX2 || c == `OP_PULL_INDEX2) ? 16'h1 : 16'h0);
    end
  endtask
  task automatic do_reset(input logic bt, input logic [1:0] cs);
    @(posedge clk_in);
    #1;
    rst_in = 1'b1;
    boot_mode_in = bt;
    reset_cause_in = cs;
    repeat (3) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    v = (bt ? 16'hbffe : 16'hfffe) - 16'({cs, 1'b0});
    pc = {mem_u.mem_q[v], mem_u.mem_q[v + 16'h1]};
    {a, b, x, y, stk, f} = {64'h0, 8'hd0};
    note(5, pc);
    note(6, {8'h0, f});
    note(4, stk);
    op_cnt++;
  endtask
  function automatic logic [15:0] regv(input int r);
    return r == 0 ? {8'h0, a} : r == 1 ? {8'h0, b} : r == 2 ? x : y;
  endfunction
  function automatic logic [7:0] bcd(input int n);
    return {4'(n / 10), 4'(n % 10)};
  endfunction
  // ----------------------------------------------------------------------
  // Result watchers and run limit.
  // ----------------------------------------------------------------------
  always @(posedge clk_in) begin
    if (!rst_in && done_out === 1'b1) begin
      while (notes.size() > 0 && notes[0].seq == dn) begin
        cmp(obs[notes[0].sel * 16 +: 16], notes[0].val);
        void'(notes.pop_front());
      end
      dn++;
    end
    if (!rst_in && mem_we_out === 1'b1) begin
      w = wq.size() > 0 ? wq.pop_front() : 24'hxxxxxx;
      cmp(mem_addr_out, w[23:8]);
      cmp({8'h0, mem_wdata_out}, {8'h0, w[7:0]});
    end
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test();
    end
  end
  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    for (int i = 0; i < 65536; i++) mem_u.mem_q[i] = 8'($random(seed));
    for (int m = 0; m < 6; m++) begin
      if (m > 0) idle();
      do_reset(1'(m / 3), 2'(m % 3));
    end
    stk = 16'h1000 + 16'($random(seed) & 32'hfff);
    note(4, stk);
    run(`OP_LOAD_SP, stk, 3'h3);
    for (int k = 0; k < 2; k++) begin
      v = 16'($random(seed));
      if (k == 0) x = v;
      else y = v;
      note(2 + k, v);
      run(5'(`OP_LOAD_INDEX1 + k), v, 3'h3);
      idle();
      if (k == 0) lat = waits;
      else cmp(16'(waits), 16'(lat + 1));
    end
    {a, b} = 16'($random(seed));
    note(0, {8'h0, a});
    note(1, {8'h0, b});
    run(`OP_LOAD_ACC16, {a, b}, 3'h3);
    for (int k = 0; k < 2; k++) begin
      v = (k == 0 ? x : y) + {8'h0, b};
      if (k == 0) x = v;
      else y = v;
      note(2 + k, v);
      run(5'(`OP_ADD_ACC2_TO_INDEX1 + k), 16'h0, 3'h1);
      ret = k == 0 ? 16'h00ff : 16'($random(seed) & 32'hff);
      note(7, v + ret);
      run(5'(`OP_INDEXED_ADDR1 + k), ret, 3'h2);
    end
    a = a + b;
    note(0, {8'h0, a});
    run(`OP_ADD_ACC2_INTO_ACC1, 16'h0, 3'h1);
    a = a - b;
    note(0, {8'h0, a});
    run(`OP_SUB_ACC2_FROM_ACC1, 16'h0, 3'h1);
    note(0, {8'h0, a});
    note(1, {8'h0, b});
    run(`OP_COMPARE_ACC1_ACC2, 16'h0, 3'h1);
    p = $unsigned($random(seed)) % 100;
    q = $unsigned($random(seed)) % 100;
    {a, b} = {bcd(p), bcd(q)};
    run(`OP_LOAD_ACC16, {a, b}, 3'h3);
    run(`OP_ADD_ACC2_INTO_ACC1, 16'h0, 3'h1);
    a = bcd((p + q) % 100);
    note(0, {8'h0, a});
    note(1, {8'h0, b});
    run(`OP_DECIMAL_ADJUST, 16'h0, 3'h1);
    for (int r = 0; r < 4; r++) begin
      v = regv(r);
      wr(stk, v[7:0]);
      if (r > 1) wr(stk - 16'h1, v[15:8]);
      stk = stk - (r > 1 ? 16'h2 : 16'h1);
      note(4, stk);
      run(5'(`OP_PUSH_ACC1 + r), 16'h0, 3'h1);
    end
    for (int k = 0; k < 3; k++) run(5'(`OP_LOAD_ACC16 + k), ~(k == 0 ? {a, b} : k == 1 ? x : y), 3'h3);
    for (int r = 3; r >= 0; r--) begin
      note(r, regv(r));
      stk = stk + (r > 1 ? 16'h2 : 16'h1);
      note(4, stk);
      run(5'(`OP_PULL_ACC1 + r), 16'h0, 3'h1);
    end
    for (int k = 0; k < 2; k++) begin
      ret = pc + (k == 0 ? 16'h3 : 16'h2);
      v = 16'($random(seed));
      wr(stk, ret[7:0]);
      wr(stk - 16'h1, ret[15:8]);
      stk = stk - 16'h2;
      note(4, stk);
      note(5, k == 0 ? v : ret + {{8{v[7]}}, v[7:0]});
      run(5'(`OP_JUMP_TO_SUBROUTINE + k), k == 0 ? v : {8'h0, v[7:0]}, k == 0 ? 3'h3 : 3'h2);
      stk = stk + 16'h2;
      note(4, stk);
      note(5, ret);
      run(`OP_RETURN_FROM_SUBROUTINE, 16'h0, 3'h1);
      pc = ret;
    end
    a = 8'($random(seed)) & 8'hef;
    note(0, {8'h0, a});
    run(`OP_LOAD_ACC1, {8'h0, a}, 3'h2);
    f = a;
    note(6, {8'h0, f});
    run(`OP_ACC1_TO_FLAGS, 16'h0, 3'h1);
    fr = '{pc[7:0], pc[15:8], y[7:0], y[15:8], x[7:0], x[15:8], a, b, f};
    for (int i = 0; i < 9; i++) wr(stk - 16'(i), fr[i]);
    ret = pc;
    v = {8'hff, 8'($random(seed)) & 8'hfe};
    pc = {mem_u.mem_q[v], mem_u.mem_q[v + 16'h1]};
    stk = stk - 16'h9;
    note(4, stk);
    note(5, pc);
    note(6, {8'h0, f | 8'h10});
    run(`OP_INTERRUPT_ENTRY, v, 3'h1);
    ce_in = 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    ce_in = 1'b1;
    cmp(16'(mem_we_out), 16'h0);
    note(0, {8'h0, f | 8'h10});
    run(`OP_FLAGS_TO_ACC1, 16'h0, 3'h1);
    stk = stk + 16'h9;
    for (int r = 0; r < 4; r++) note(r, regv(r));
    note(4, stk);
    note(5, ret);
    note(6, {8'h0, f});
    run(`OP_RETURN_FROM_INTERRUPT, 16'h0, 3'h1);
    idle();
    repeat (2) @(posedge clk_in);
    finish_test();
  end
endmodule // cpu_program_model_stack_bench
`default_nettype wire
